// *** hw/tcr_timer.sv ***
// module: 16-bit capture/reload timer with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none

module tcr_timer (
   input  wire logic        clock,
   input  wire logic        rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // pins and system side
   input  wire logic        extCountPin,
   input  wire logic        extTriggerPin,
   output logic             timerIrq,
   output logic             baudTick
);

   tcr_pkg::tcr_state_t s;
   tcr_pkg::tcr_state_t n;

   logic [1:0] pinLevel;
   logic [1:0] pinFall;

   // ----------------------------------------
   // helpers
   // ----------------------------------------

   // one-hot register select, shared by read and write paths
   function automatic logic [3:0] reg_sel(
      input logic [7:0] a,
      input logic       hit
   );
      logic [3:0] r;
      r    = 4'h0;
      r[0] = hit && (a == tcr_pkg::OFS_CONTROL);
      r[1] = hit && (a == tcr_pkg::OFS_MODE);
      r[2] = hit && (a == tcr_pkg::OFS_COUNT);
      r[3] = hit && (a == tcr_pkg::OFS_CAPTURE);
      return r;
   endfunction

   // baud selects take precedence over the other modes
   function automatic tcr_pkg::tcr_mode_t mode_of(
      input tcr_pkg::tcr_ctrl_t c,
      input tcr_pkg::tcr_cfg_t  g
   );
      tcr_pkg::tcr_mode_t m;
      if (c.rxBaudSelect || c.txBaudSelect) begin
         m = tcr_pkg::MD_BAUD;
      end else if (c.captureReloadSelect) begin
         m = tcr_pkg::MD_CAPTURE;
      end else if (g.updownEnable) begin
         m = tcr_pkg::MD_UPDOWN;
      end else begin
         m = tcr_pkg::MD_RELOAD;
      end
      return m;
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   tcr_edge_sync #(
      .N (2)
   ) u_pins (
      .clock (clock),
      .rst   (rst),
      .pins  ({extTriggerPin, extCountPin}),
      .level (pinLevel),
      .fall  (pinFall)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic               addrPhase;
   logic [3:0]         wrSel;
   logic [3:0]         rdSel;
   logic [3:0]         prescLast;
   logic               prescTick;
   logic               countTick;
   logic               trigEvent;
   logic               countUp;
   tcr_pkg::tcr_mode_t mode;

   always_comb begin
      n          = s;
      n.baudTick = 1'b0;

      // bus decode: the address phase is taken when hready is high
      addrPhase = hsel && hready && htrans[1];
      wrSel     = s.wrPend ? reg_sel(s.addr, s.hit) : 4'h0;
      rdSel     = reg_sel(haddr[7:0], haddr[31:tcr_pkg::DEC_HI_BIT] == 28'h0000000);

      // software writes to control, mode and capture land first;
      // hardware events below then win over them
      if (wrSel[0]) begin
         n.ctrl = tcr_pkg::tcr_ctrl_t'(hwdata[7:0]);
      end
      if (wrSel[1]) begin
         n.cfg = tcr_pkg::tcr_cfg_t'(hwdata[2:0]);
      end
      if (wrSel[3]) begin
         n.capture = hwdata[15:0];
      end

      // free-running prescaler, 12 or 4 clocks per tick
      prescLast = s.cfg.fastPrescale ? tcr_pkg::DIV_FAST_LAST : tcr_pkg::DIV_SLOW_LAST;
      // a switch from /12 to /4 may leave the prescaler past the new last value
      prescTick = (s.presc >= prescLast);
      n.presc   = prescTick ? tcr_pkg::PRESC_RST : s.presc + 4'h1;

      // counting source and run gate
      countTick = s.ctrl.runEnable &&
                  (s.ctrl.countSourceSelect ? pinFall[tcr_pkg::PIN_COUNT]
                                            : prescTick);
      trigEvent = s.ctrl.extTriggerEnable && pinFall[tcr_pkg::PIN_TRIG];
      countUp   = pinLevel[tcr_pkg::PIN_TRIG];
      mode      = mode_of(s.ctrl, s.cfg);

      unique case (mode)
         tcr_pkg::MD_CAPTURE: begin
            if (countTick) begin
               n.count = s.count + 16'h0001;
               if (s.count == tcr_pkg::COUNT_MAX) begin
                  n.ctrl.overflowFlag = 1'b1;
               end
            end
            if (trigEvent) begin
               n.capture           = s.count;
               n.ctrl.extEventFlag = 1'b1;
               if (s.cfg.captureAutoClear) begin
                  n.count = tcr_pkg::COUNT_RST;
               end
            end
         end
         tcr_pkg::MD_RELOAD: begin
            // a trigger reload in the same cycle supersedes the tick
            if (trigEvent) begin
               n.count             = s.capture;
               n.ctrl.extEventFlag = 1'b1;
            end else if (countTick) begin
               if (s.count == tcr_pkg::COUNT_MAX) begin
                  n.count             = s.capture;
                  n.ctrl.overflowFlag = 1'b1;
               end else begin
                  n.count = s.count + 16'h0001;
               end
            end
         end
         tcr_pkg::MD_UPDOWN: begin
            if (countTick) begin
               if (countUp) begin
                  if (s.count == tcr_pkg::COUNT_MAX) begin
                     n.count             = s.capture;
                     n.ctrl.overflowFlag = 1'b1;
                     n.ctrl.extEventFlag = ~s.ctrl.extEventFlag;
                  end else begin
                     n.count = s.count + 16'h0001;
                  end
               end else begin
                  if (s.count == s.capture) begin
                     n.count             = tcr_pkg::COUNT_MAX;
                     n.ctrl.overflowFlag = 1'b1;
                     n.ctrl.extEventFlag = ~s.ctrl.extEventFlag;
                  end else begin
                     n.count = s.count - 16'h0001;
                  end
               end
            end
         end
         tcr_pkg::MD_BAUD: begin
            // rollover feeds the serial port, the overflow flag stays
            if (countTick) begin
               if (s.count == tcr_pkg::COUNT_MAX) begin
                  n.count    = s.capture;
                  n.baudTick = 1'b1;
               end else begin
                  n.count = s.count + 16'h0001;
               end
            end
            if (trigEvent) begin
               n.ctrl.extEventFlag = 1'b1;
            end
         end
      endcase

      // a count write by software wins over the hardware count
      if (wrSel[2]) begin
         n.count = hwdata[15:0];
      end

      // latch the address phase for the following data phase
      n.wrPend = addrPhase && hwrite;
      if (addrPhase) begin
         n.addr = haddr[7:0];
         n.hit  = (haddr[31:tcr_pkg::DEC_HI_BIT] == 28'h0000000);
      end

      // read data registered at the address phase; unmapped reads zero
      n.rdata = 32'h00000000;
      if (addrPhase && !hwrite) begin
         unique case (1'b1)
            rdSel[0]: n.rdata = {24'h000000, s.ctrl};
            rdSel[1]: n.rdata = {29'h00000000, s.cfg};
            rdSel[2]: n.rdata = {16'h0000, s.count};
            rdSel[3]: n.rdata = {16'h0000, s.capture};
            default:  n.rdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         s.ctrl     <= tcr_pkg::CTRL_RST;
         s.cfg      <= tcr_pkg::CFG_RST;
         s.count    <= tcr_pkg::COUNT_RST;
         s.capture  <= tcr_pkg::CAPTURE_RST;
         s.presc    <= tcr_pkg::PRESC_RST;
         s.baudTick <= 1'b0;
         s.addr     <= 8'h00;
         s.hit      <= 1'b0;
         s.wrPend   <= 1'b0;
         s.rdata    <= 32'h00000000;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // zero-wait slave: every transfer completes in one data phase
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s.rdata;
   assign baudTick  = s.baudTick;

   // flags are never cleared here on service, only by a control write;
   // in up/down mode the event flag only toggles and requests nothing
   assign timerIrq = s.ctrl.overflowFlag ||
                     (s.ctrl.extEventFlag &&
                      (mode_of(s.ctrl, s.cfg) != tcr_pkg::MD_UPDOWN));

endmodule

`default_nettype wire

// *** hw/tcr_pkg.sv ***
// package: constants, field layouts and types of the capture/reload timer
package tcr_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_MODE    = 8'h04;
   localparam logic [7:0] OFS_COUNT   = 8'h08;
   localparam logic [7:0] OFS_CAPTURE = 8'h0c;
   localparam int unsigned DEC_HI_BIT = 4;

   // ----------------------------------------
   // widths, counts and reset values
   // ----------------------------------------
   localparam int unsigned COUNT_W = 16;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;
   localparam logic [15:0] COUNT_RST   = 16'h0000;
   localparam logic [15:0] CAPTURE_RST = 16'h0000;
   localparam logic [3:0]  DIV_SLOW_LAST = 4'hb;
   localparam logic [3:0]  DIV_FAST_LAST = 4'h3;
   localparam logic [3:0]  PRESC_RST     = 4'h0;
   localparam int unsigned PIN_COUNT = 0;
   localparam int unsigned PIN_TRIG  = 1;

   // control word, bit 7 down to bit 0
   typedef struct packed {
      logic overflowFlag;
      logic extEventFlag;
      logic rxBaudSelect;
      logic txBaudSelect;
      logic extTriggerEnable;
      logic runEnable;
      logic countSourceSelect;
      logic captureReloadSelect;
   } tcr_ctrl_t;

   // mode word, bit 2 down to bit 0
   typedef struct packed {
      logic fastPrescale;
      logic captureAutoClear;
      logic updownEnable;
   } tcr_cfg_t;

   localparam tcr_ctrl_t CTRL_RST = 8'h00;
   localparam tcr_cfg_t  CFG_RST  = 3'h0;

   typedef enum logic [3:0] {
      MD_CAPTURE = 4'h1,
      MD_RELOAD  = 4'h2,
      MD_UPDOWN  = 4'h4,
      MD_BAUD    = 4'h8
   } tcr_mode_t;

   // whole state of the timer top
   typedef struct packed {
      tcr_ctrl_t   ctrl;
      tcr_cfg_t    cfg;
      logic [15:0] count;
      logic [15:0] capture;
      logic [3:0]  presc;
      logic        baudTick;
      logic [7:0]  addr;
      logic        hit;
      logic        wrPend;
      logic [31:0] rdata;
   } tcr_state_t;

endpackage

// *** hw/tcr_edge_sync.sv ***
// module: pin synchroniser with level and falling-edge outputs
`timescale 1ns/100ps
`default_nettype none

module tcr_edge_sync #(
   parameter int unsigned N = 2
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [N-1:0] pins,
   output logic      [N-1:0] level,
   output logic      [N-1:0] fall
);

   typedef struct packed {
      logic [N-1:0] meta;
      logic [N-1:0] cur;
      logic [N-1:0] prev;
   } tcr_edge_state_t;

   tcr_edge_state_t s;
   tcr_edge_state_t n;

   // ----------------------------------------
   // sampling chain
   // ----------------------------------------
   // meta feeds only cur; edges look at cur and prev
   always_comb begin
      n      = s;
      n.meta = pins;
      n.cur  = s.meta;
      n.prev = s.cur;
   end

   // cleared chain reads low, so a pin high at reset gives no edge
   always_ff @(posedge clock) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // high sample then low sample, one pulse per edge
   assign fall  = s.prev & ~s.cur;
   assign level = s.cur;

endmodule

`default_nettype wire

// *** tb/tcr_asserts.sv ***
// checker: bus answer and output timing properties of the capture/reload timer
`timescale 1ns/100ps
`default_nettype none

module tcr_asserts (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        timerIrq,
   input wire logic        baudTick
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic       wrAddr;
   logic       rdAddr;
   logic       wrCtl_q;
   logic [1:0] sel_q;
   // accepted address phases
   assign wrAddr = hsel && hready && htrans[1] && hwrite;
   assign rdAddr = hsel && hready && htrans[1] && !hwrite;
   // software copy of baud and trigger enable; hardware never alters them
   always_ff @(posedge clock) begin
      if (rst) begin
         wrCtl_q <= 1'b0;
         sel_q   <= 2'h0;
      end else begin
         wrCtl_q <= wrAddr && (haddr == 32'h0);
         if (wrCtl_q) begin
            sel_q <= {|hwdata[5:4], hwdata[3]};
         end
      end
   end
   sequence s_tickGap;
      !baudTick [*3];
   endsequence
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (!hresp) else $error("hresp not okay");
   a_rdata_idle: assert property (!$past(rdAddr) |-> hrdata == 32'h0) else $error("hrdata outside data phase");
   a_reset_quiet: assert property ($fell(rst) |-> !timerIrq && !baudTick && hrdata == 32'h0)
      else $error("outputs not quiet after reset");
   a_tick_spaced: assert property (baudTick |=> s_tickGap) else $error("baud pulses too close");
   a_tick_in_baud: assert property (baudTick |-> sel_q[1] || $past(sel_q[1]))
      else $error("baud pulse outside baud mode");
   a_irq_held: assert property ($fell(timerIrq) |-> $past(wrAddr, 2))
      else $error("request dropped without software write");
   a_baud_no_ovf: assert property (sel_q[1] && !sel_q[0] && $rose(timerIrq) |-> $past(wrAddr, 2))
      else $error("rollover raised a request in baud mode");
endmodule
`default_nettype wire

// *** tb/tcr_pin_model.sv ***
// partner: drives the external count and trigger pins
`timescale 1ns/100ps
`default_nettype none

module tcr_pin_model (
   input  wire logic clock,
   output logic      countPin,
   output logic      trigPin
);
   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   // idle high, as a pulled-up pin would be
   initial begin
      countPin = 1'b1;
      trigPin  = 1'b1;
   end
   // each level held two cycles or more so the sync sees it once
   task automatic count_pulses(input int n);
      repeat (n) begin
         @(posedge clock);
         countPin <= 1'b0;
         repeat (2) @(posedge clock);
         countPin <= 1'b1;
         repeat (2) @(posedge clock);
      end
   endtask
   // level also sets direction in up/down mode
   task automatic set_trig(input logic v);
      @(posedge clock);
      trigPin <= v;
      repeat (4) @(posedge clock);
   endtask
   task automatic trig_fall();
      set_trig(1'b0);
      set_trig(1'b1);
   endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// testbench: register bus, pin partner and mode scenarios of the capture/reload timer
`timescale 1ns/100ps
`default_nettype none

module tb;
   // ----------------------------------------
   // bench signals and instances
   // ----------------------------------------
   localparam logic [31:0] A_CTL = 32'(tcr_pkg::OFS_CONTROL);
   localparam logic [31:0] A_MOD = 32'(tcr_pkg::OFS_MODE);
   localparam logic [31:0] A_CNT = 32'(tcr_pkg::OFS_COUNT);
   localparam logic [31:0] A_CAP = 32'(tcr_pkg::OFS_CAPTURE);
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        hreadyout, hresp, countPin, trigPin, timerIrq, baudTick;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          cycleCnt = 0;
   int          ticks = 0;
   always #20 clock = ~clock;
   tcr_timer u_dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .extCountPin(countPin),
      .extTriggerPin(trigPin), .timerIrq, .baudTick);
   tcr_pin_model u_pins (.clock, .countPin, .trigPin);
   // baud pulse tally and hang guard; whole run is about a thousand cycles
   always @(posedge clock) begin
      cycleCnt <= cycleCnt + 1;
      if (baudTick === 1'b1) ticks <= ticks + 1;
      if (cycleCnt == 20000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   // one single transfer; zero wait states assumed nowhere, hready polled
   task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // step past the write edge so later output checks see the settled state
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(a, d, 1'b1);
      #1;
   endtask
   task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
      xfer(a, 32'h0, 1'b0);
      chk(n, rd, e);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rdc("control", A_CTL, 32'h0);
      rdc("mode", A_MOD, 32'h0);
      rdc("count", A_CNT, 32'h0);
      rdc("capture", A_CAP, 32'h0);
      rdc("unmapped", 32'h10, 32'h0);
      chk("irq", 32'(timerIrq), 32'h0);
   endtask
   // run windows of 120 and 40 edges hold exactly ten ticks
   task automatic t_prescale();
      for (int i = 0; i < 2; i++) begin
         wr(A_CNT, 32'h0);
         wr(A_MOD, (i == 1) ? 32'h4 : 32'h0);
         wr(A_CTL, 32'h5);
         repeat ((i == 1) ? 37 : 117) @(posedge clock);
         wr(A_CTL, 32'h1);
         rdc("prescaled count", A_CNT, 32'ha);
         repeat (30) @(posedge clock);
         rdc("held count", A_CNT, 32'ha);
      end
   endtask
   task automatic t_extcount();
      wr(A_CNT, 32'h0);
      wr(A_CTL, 32'h7);
      u_pins.count_pulses(5);
      repeat (6) @(posedge clock);
      wr(A_CTL, 32'h1);
      rdc("pin count", A_CNT, 32'h5);
   endtask
   task automatic t_capture();
      wr(A_MOD, 32'h6);
      wr(A_CNT, 32'hfffe);
      wr(A_CTL, 32'h5);
      repeat (9) @(posedge clock);
      wr(A_CTL, 32'h81);
      rdc("wrapped count", A_CNT, 32'h1);
      rdc("overflow", A_CTL, 32'h81);
      chk("irq", 32'(timerIrq), 32'h1);
      wr(A_CNT, 32'h1234);
      wr(A_CTL, 32'h9);
      chk("irq", 32'(timerIrq), 32'h0);
      u_pins.trig_fall();
      repeat (6) @(posedge clock);
      rdc("capture", A_CAP, 32'h1234);
      rdc("cleared count", A_CNT, 32'h0);
      rdc("event", A_CTL, 32'h49);
      chk("irq", 32'(timerIrq), 32'h1);
      wr(A_CNT, 32'h55);
      repeat (10) @(posedge clock);
      rdc("single capture", A_CAP, 32'h1234);
   endtask
   task automatic t_reload();
      wr(A_MOD, 32'h4);
      wr(A_CAP, 32'h100);
      wr(A_CNT, 32'h0);
      wr(A_CTL, 32'h8);
      u_pins.trig_fall();
      repeat (6) @(posedge clock);
      rdc("trigger reload", A_CNT, 32'h100);
      rdc("event", A_CTL, 32'h48);
      wr(A_CNT, 32'hffff);
      wr(A_CTL, 32'h4);
      repeat (1) @(posedge clock);
      wr(A_CTL, 32'h80);
      rdc("wrap reload", A_CNT, 32'h100);
      rdc("overflow", A_CTL, 32'h80);
   endtask
   task automatic t_updown();
      u_pins.set_trig(1'b0);
      wr(A_MOD, 32'h5);
      wr(A_CAP, 32'h10);
      wr(A_CNT, 32'h12);
      wr(A_CTL, 32'h4);
      repeat (11) @(posedge clock);
      rdc("down reload", A_CTL, 32'hc4);
      chk("irq", 32'(timerIrq), 32'h1);
      wr(A_CTL, 32'h0);
      xfer(A_CNT, 32'h0, 1'b0);
      chk("down count", 32'(rd >= 32'hfffd && rd <= 32'hffff), 32'h1);
      u_pins.set_trig(1'b1);
      wr(A_CNT, 32'hfffe);
      wr(A_CTL, 32'h4);
      repeat (7) @(posedge clock);
      rdc("up reload", A_CTL, 32'hc4);
      repeat (3) @(posedge clock);
      wr(A_CTL, 32'h40);
      rdc("up count", A_CNT, 32'h12);
      chk("irq", 32'(timerIrq), 32'h0);
   endtask
   // both baud selects; 50 ticks from fff0 give three rollovers
   task automatic t_baud();
      int          t0;
      logic [31:0] sel;
      for (int i = 0; i < 2; i++) begin
         sel = (i == 1) ? 32'h20 : 32'h10;
         wr(A_MOD, 32'h4);
         wr(A_CAP, 32'hfff0);
         wr(A_CNT, 32'hfff0);
         t0 = ticks;
         wr(A_CTL, sel | 32'h4);
         repeat (197) @(posedge clock);
         wr(A_CTL, sel);
         repeat (4) @(posedge clock);
         chk("baud pulses", 32'(ticks - t0), 32'h3);
         rdc("no overflow", A_CTL, sel);
         wr(A_CTL, sel | 32'h8);
         u_pins.trig_fall();
         repeat (6) @(posedge clock);
         rdc("baud event", A_CTL, sel | 32'h48);
         chk("irq", 32'(timerIrq), 32'h1);
         wr(A_CTL, sel | 32'h80);
         chk("irq", 32'(timerIrq), 32'h1);
         wr(A_CTL, 32'h0);
      end
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_prescale();
      t_extcount();
      t_capture();
      t_reload();
      t_updown();
      t_baud();
      final_report();
   end
endmodule

bind tcr_timer tcr_asserts u_chk (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hreadyout, .hresp, .hrdata, .timerIrq, .baudTick);
`default_nettype wire
